/* File: rtl/cbnode_seq.sv */
// Capture buffer node sequencer: node table, sample FIFO, packet triggers and AXI4-Lite registers
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cbnode_seq #(
  parameter int NODES = 32
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  ARST_N_I,
  input  wire logic                  AXI_AWVALID_I,
  output logic                       AXI_AWREADY_O,
  input  wire logic [11:0]           AXI_AWADDR_I,
  input  wire logic                  AXI_WVALID_I,
  output logic                       AXI_WREADY_O,
  input  wire logic [31:0]           AXI_WDATA_I,
  input  wire logic [3:0]            AXI_WSTRB_I,
  output logic                       AXI_BVALID_O,
  input  wire logic                  AXI_BREADY_I,
  output logic [1:0]                 AXI_BRESP_O,
  input  wire logic                  AXI_ARVALID_I,
  output logic                       AXI_ARREADY_O,
  input  wire logic [11:0]           AXI_ARADDR_I,
  output logic                       AXI_RVALID_O,
  input  wire logic                  AXI_RREADY_I,
  output logic [31:0]                AXI_RDATA_O,
  output logic [1:0]                 AXI_RRESP_O,
  input  wire logic                  CHIRP_AVAIL_I,
  input  wire logic                  DMA_VALID_I,
  input  wire logic [15:0]           DMA_DATA_I,
  output logic                       DMA_READY_O,
  output logic [6:0]                 DMA_REQ_O,
  input  wire logic [15:0]           ADC_CRC_I,
  output logic                       HSI_VALID_O,
  input  wire logic                  HSI_READY_I,
  output cbnode_pkg::hsi_word_t      HSI_O,
  output logic                       CHAIN_DONE_O
);
  import cbnode_pkg::*;

  localparam int FILL_W = FIFO_AW + 1;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_CHECK = 3'b010,
    S_HS    = 3'b011,
    S_HDR   = 3'b100,
    S_DATA  = 3'b101,
    S_END   = 3'b110,
    S_DONE  = 3'b111
  } state_t;

  state_t                    state;
  state_t                    next_state;
  logic                      lvds;
  logic                      swrst;
  logic                      sw_trig;
  logic                      aw_held;
  logic                      w_held;
  logic [11:0]               aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      ar_held;
  logic [11:0]               ar_addr;
  logic                      rd_wait;
  logic                      do_write;
  logic                      rd_mem_go;
  logic                      seq_mem;
  logic [31:0]               tbl_q;
  logic [1:0]                fcnt;
  logic [NODE_AW-1:0]        node_idx;
  node_ctrl_t                nctl;
  logic [31:0]               nhdr;
  node_thresh_t              nthr;
  logic [SAMPLE_CNT_W-1:0]   rx_cnt;
  logic [SAMPLE_CNT_W-1:0]   tx_cnt;
  logic [FIFO_AW-1:0]        wr_ptr;
  logic [FIFO_AW-1:0]        rd_ptr;
  logic [FILL_W-1:0]         fill;
  logic [15:0]               fifo_q;
  logic [15:0]               crc;
  logic                      crc_error;
  logic                      chain_done;
  logic                      push;
  logic                      pop;
  logic                      chan_free;
  logic                      emit_hs;
  logic                      emit_hdr;
  logic                      emit_he;
  logic                      start;
  logic                      rx_done;
  logic                      node_last;
  hsi_word_t                 hsi_q;
  status_t                   status;

  function automatic logic is_node(input logic [11:0] a);
    return a[11:9] == ADDR_NODE_BASE[11:9] && a[3:2] != 2'h3;
  endfunction : is_node

  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [15:0] d);
    logic [15:0] c;
    c = c_in;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_step

  // AXI4-Lite write channel: address and data taken in either order
  assign AXI_AWREADY_O = !aw_held && !AXI_BVALID_O;
  assign AXI_WREADY_O  = !w_held && !AXI_BVALID_O;
  assign do_write      = aw_held && w_held && !AXI_BVALID_O;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= AXI_AWADDR_I;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= AXI_WDATA_I;
        w_strb <= AXI_WSTRB_I;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O  <= RESP_OKAY;
    end else if (do_write) begin
      AXI_BVALID_O <= 1'b1;
      AXI_BRESP_O  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_STATUS || is_node(aw_addr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (AXI_BREADY_I) begin
      AXI_BVALID_O <= 1'b0;
    end
  end

  // Control register; trigger bit is self-clearing and never reads back
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lvds    <= CTRL_LVDS_RST;
      swrst   <= CTRL_SWRST_RST;
      sw_trig <= 1'b0;
    end else begin
      sw_trig <= do_write && aw_addr == ADDR_CTRL && w_strb[0] && w_data[CTRL_TRIG_BIT];
      if (do_write && aw_addr == ADDR_CTRL && w_strb[0]) begin
        lvds  <= w_data[CTRL_LVDS_BIT];
        swrst <= w_data[CTRL_SWRST_BIT];
      end
    end
  end

  // Sticky status flags: a new event wins over a write-one-to-clear
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      crc_error  <= 1'b0;
      chain_done <= 1'b0;
    end else begin
      if (state == S_DATA && next_state == S_END && nctl.crc_check_en && crc != ADC_CRC_I) begin
        crc_error <= 1'b1;
      end else if (do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[3]) begin
        crc_error <= 1'b0;
      end
      if (state == S_DONE) begin
        chain_done <= 1'b1;
      end else if (do_write && aw_addr == ADDR_STATUS && w_strb[0] && w_data[1]) begin
        chain_done <= 1'b0;
      end
    end
  end

  always_comb begin
    status            = '0;
    status.fifo_fill  = 8'(fill);
    status.node_index = node_idx;
    status.crc_error  = crc_error;
    status.chain_done = chain_done;
    status.busy       = state != S_IDLE;
  end

  // AXI4-Lite read channel; node words wait while the walk fetches from the table
  assign AXI_ARREADY_O = !ar_held && !AXI_RVALID_O;
  assign seq_mem       = state == S_FETCH && fcnt != 2'h3;
  assign rd_mem_go     = ar_held && !AXI_RVALID_O && !rd_wait && is_node(ar_addr) && !seq_mem;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ar_held      <= 1'b0;
      ar_addr      <= '0;
      rd_wait      <= 1'b0;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O  <= '0;
      AXI_RRESP_O  <= RESP_OKAY;
    end else begin
      rd_wait <= rd_mem_go;
      if (AXI_ARVALID_I && AXI_ARREADY_O) begin
        ar_held <= 1'b1;
        ar_addr <= AXI_ARADDR_I;
      end else if (rd_wait || (ar_held && !AXI_RVALID_O && !is_node(ar_addr))) begin
        ar_held      <= 1'b0;
        AXI_RVALID_O <= 1'b1;
        AXI_RRESP_O  <= RESP_OKAY;
        if (rd_wait) begin
          AXI_RDATA_O <= tbl_q;
        end else if (ar_addr == ADDR_CTRL) begin
          AXI_RDATA_O <= 32'({swrst, lvds});
        end else if (ar_addr == ADDR_STATUS) begin
          AXI_RDATA_O <= status;
        end else begin
          AXI_RDATA_O <= '0;
          AXI_RRESP_O <= RESP_SLVERR;
        end
      end else if (AXI_RVALID_O && AXI_RREADY_I) begin
        AXI_RVALID_O <= 1'b0;
      end
    end
  end

  cbnode_ram #(
    .W  (32),
    .AW (NODE_AW + 2)
  ) u_node_table (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .we_i     (do_write && is_node(aw_addr)),
    .waddr_i  ({aw_addr[8:4], aw_addr[3:2]}),
    .wbe_i    (w_strb),
    .wdata_i  (w_data),
    .re_i     (seq_mem || rd_mem_go),
    .raddr_i  (seq_mem ? {node_idx, fcnt} : {ar_addr[8:4], ar_addr[3:2]}),
    .rdata_o  (tbl_q)
  );

  // Node walk
  assign start     = state == S_IDLE && (CHIRP_AVAIL_I || sw_trig);
  assign rx_done   = rx_cnt == nctl.sample_count && tx_cnt == nctl.sample_count;
  assign node_last = node_idx == NODE_AW'(NODES - 1);
  assign chan_free = !HSI_VALID_O || HSI_READY_I;

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:  if (start) next_state = S_FETCH;
      S_FETCH: if (fcnt == 2'h3) next_state = S_CHECK;
      S_CHECK: begin
        if (!nctl.node_valid) next_state = S_DONE;
        else if (!lvds && nctl.line_start_flag) next_state = S_HS;
        else next_state = S_HDR;
      end
      S_HS:    if (chan_free) next_state = S_HDR;
      S_HDR:   if (chan_free || !emit_hdr) next_state = S_DATA;
      S_DATA:  if (rx_done) next_state = S_END;
      S_END:   if (chan_free || !emit_he) next_state = node_last ? S_DONE : S_FETCH;
      S_DONE:  next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= S_IDLE;
    end else if (swrst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fcnt     <= '0;
      node_idx <= '0;
      nctl     <= '0;
      nhdr     <= '0;
      nthr     <= '0;
    end else begin
      fcnt <= (state == S_FETCH) ? fcnt + 2'h1 : 2'h0;
      if (start || swrst) begin
        node_idx <= '0;
      end else if (state == S_END && next_state == S_FETCH) begin
        node_idx <= node_idx + NODE_AW'(1);
      end
      if (state == S_FETCH) begin
        unique case (fcnt)
          2'h1:    nctl <= tbl_q;
          2'h2:    nhdr <= tbl_q;
          2'h3:    nthr <= tbl_q;
          default: ;
        endcase
      end
    end
  end

  // Sample FIFO with fill-based stall and drain gating
  assign DMA_READY_O = state == S_DATA && rx_cnt != nctl.sample_count
                       && fill <= FILL_W'(nthr.fill_stall_threshold)
                       && fill != FILL_W'(1 << FIFO_AW);
  assign push        = DMA_VALID_I && DMA_READY_O;
  assign pop         = state == S_DATA && fill != '0 && tx_cnt != nctl.sample_count && chan_free
                       && (fill >= FILL_W'(nthr.drain_threshold) || rx_cnt == nctl.sample_count);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
      rx_cnt <= '0;
      tx_cnt <= '0;
      crc    <= CRC_INIT;
    end else if (swrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
      rx_cnt <= '0;
      tx_cnt <= '0;
      crc    <= CRC_INIT;
    end else begin
      wr_ptr <= wr_ptr + FIFO_AW'(push);
      rd_ptr <= rd_ptr + FIFO_AW'(pop);
      fill   <= fill + FILL_W'(push) - FILL_W'(pop);
      if (state == S_CHECK) begin
        rx_cnt <= '0;
        tx_cnt <= '0;
        crc    <= CRC_INIT;
      end else begin
        rx_cnt <= rx_cnt + SAMPLE_CNT_W'(push);
        tx_cnt <= tx_cnt + SAMPLE_CNT_W'(pop);
        if (push) begin
          crc <= crc_step(crc, DMA_DATA_I);
        end
      end
    end
  end

  cbnode_ram #(
    .W  (16),
    .AW (FIFO_AW)
  ) u_sample_fifo (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .we_i     (push),
    .waddr_i  (wr_ptr),
    .wbe_i    (2'h3),
    .wdata_i  (DMA_DATA_I),
    .re_i     (pop),
    .raddr_i  (rd_ptr),
    .rdata_o  (fifo_q)
  );

  // Protocol engine channel; every item carries the node's format settings
  assign emit_hs  = state == S_HS;
  assign emit_hdr = state == S_HDR && !lvds && !nctl.continue_packet_flag;
  assign emit_he  = state == S_END && !lvds && nctl.line_end_flag;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      HSI_VALID_O <= 1'b0;
      hsi_q       <= '0;
    end else if (swrst) begin
      HSI_VALID_O <= 1'b0;
    end else if (chan_free) begin
      HSI_VALID_O <= emit_hs || emit_hdr || emit_he || pop;
      if (emit_hs || emit_hdr || emit_he || pop) begin
        hsi_q.kind        <= emit_hs ? PK_LINE_START : emit_hdr ? PK_LONG_HDR : emit_he ? PK_LINE_END : PK_DATA;
        hsi_q.word        <= emit_hdr ? nhdr : 32'h0000_0000;
        hsi_q.vc          <= nctl.virtual_channel_sel;
        hsi_q.width       <= nctl.output_width_sel;
        hsi_q.lane_map    <= nctl.lane_map_sel;
        hsi_q.aligned128  <= !nctl.input_alignment;
        hsi_q.frame_first <= lvds && nctl.line_start_flag;
        hsi_q.frame_new   <= lvds && !nctl.continue_packet_flag;
      end
    end
  end

  // Sample words come straight from the FIFO read register to save a stage
  always_comb begin
    HSI_O = hsi_q;
    if (hsi_q.kind == PK_DATA) begin
      HSI_O.word = {16'h0000, fifo_q};
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DMA_REQ_O    <= '0;
      CHAIN_DONE_O <= 1'b0;
    end else begin
      CHAIN_DONE_O <= state == S_DONE;
      if (state == S_HDR && next_state == S_DATA && !nctl.continue_packet_flag
          && nthr.dma_line_sel != DMA_LINE_NONE) begin
        DMA_REQ_O <= DMA_LINES'(7'h01 << nthr.dma_line_sel);
      end else begin
        DMA_REQ_O <= '0;
      end
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I || swrst);

  sequence s_hs_issue;
    state == S_HS && chan_free;
  endsequence

  sequence s_hdr_issue;
    state == S_HDR && chan_free && !lvds && !nctl.continue_packet_flag;
  endsequence

  a_invalid_ends: assert property (state == S_CHECK && !nctl.node_valid |=> state == S_DONE ##1 state == S_IDLE)
    else $error("invalid node did not end the chain");
  a_hs_packet: assert property (s_hs_issue |=> HSI_VALID_O && hsi_q.kind == PK_LINE_START)
    else $error("line start packet missing");
  a_header_word: assert property (s_hdr_issue |=> HSI_VALID_O && hsi_q.word == nhdr && hsi_q.vc == nctl.virtual_channel_sel)
    else $error("long header word or channel wrong");
  a_lvds_no_short: assert property (HSI_VALID_O && hsi_q.kind != PK_DATA |-> !lvds)
    else $error("control packet emitted in lvds mode");
  a_dma_line: assert property ((state == S_HDR && next_state == S_DATA && !nctl.continue_packet_flag)
                               |=> DMA_REQ_O == ((nthr.dma_line_sel == DMA_LINE_NONE) ? 7'h00 : 7'(7'h01 << nthr.dma_line_sel)))
    else $error("dma request line wrong");
  a_fill_stall: assert property (fill > FILL_W'(nthr.fill_stall_threshold) |-> !DMA_READY_O)
    else $error("dma not stalled above fill threshold");
  a_drain_hold: assert property (pop |-> fill >= FILL_W'(nthr.drain_threshold) || rx_cnt == nctl.sample_count)
    else $error("data drained below threshold");
  a_count_exact: assert property (push |-> rx_cnt < nctl.sample_count)
    else $error("more units accepted than sample count");
  a_data_format: assert property (pop |=> HSI_VALID_O && hsi_q.kind == PK_DATA && hsi_q.width == nctl.output_width_sel
                                  && hsi_q.lane_map == nctl.lane_map_sel)
    else $error("data format fields do not follow the node");
  a_he_after_data: assert property (state == S_DATA && next_state == S_END && !lvds && nctl.line_end_flag
                                    |=> ##[0:300] (HSI_VALID_O && hsi_q.kind == PK_LINE_END))
    else $error("line end packet missing");

endmodule : cbnode_seq

/* File: rtl/cbnode_pkg.sv */
// Shared constants, register map and carrier types for the capture buffer node sequencer
package cbnode_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          NODE_AW        = 5;
  localparam int          NODE_COUNT     = 32;
  localparam int          SAMPLE_CNT_W   = 14;
  localparam int          FIFO_AW        = 7;

  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_NODE_BASE = 12'h200;
  localparam logic [1:0]  WORD_CONTROL   = 2'h0;
  localparam logic [1:0]  WORD_HEADER    = 2'h1;
  localparam logic [1:0]  WORD_THRESH    = 2'h2;

  localparam int          CTRL_LVDS_BIT  = 0;
  localparam int          CTRL_SWRST_BIT = 1;
  localparam int          CTRL_TRIG_BIT  = 2;
  localparam logic        CTRL_LVDS_RST  = 1'h0;
  localparam logic        CTRL_SWRST_RST = 1'h0;

  localparam logic [1:0]  WIDTH_16       = 2'h0;
  localparam logic [1:0]  WIDTH_14       = 2'h1;
  localparam logic [1:0]  WIDTH_12       = 2'h2;
  localparam logic [2:0]  DMA_LINE_NONE  = 3'h7;
  localparam int          DMA_LINES      = 7;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h1021;

  typedef struct packed {
    logic [6:0]  unused;
    logic [13:0] sample_count;
    logic        crc_check_en;
    logic        continue_packet_flag;
    logic        input_alignment;
    logic        lane_map_sel;
    logic [1:0]  output_width_sel;
    logic [1:0]  virtual_channel_sel;
    logic        line_start_flag;
    logic        line_end_flag;
    logic        node_valid;
  } node_ctrl_t;

  typedef struct packed {
    logic [12:0] unused;
    logic [2:0]  dma_line_sel;
    logic [7:0]  fill_stall_threshold;
    logic [7:0]  drain_threshold;
  } node_thresh_t;

  // Bit positions match the write-one-to-clear decode: chain_done bit 1, crc_error bit 3, index [12:8]
  typedef struct packed {
    logic [7:0]  fifo_fill;
    logic [10:0] unused_hi;
    logic [4:0]  node_index;
    logic [3:0]  unused_mid;
    logic        crc_error;
    logic        unused_lo;
    logic        chain_done;
    logic        busy;
  } status_t;

  typedef enum logic [1:0] {
    PK_DATA       = 2'b00,
    PK_LINE_START = 2'b01,
    PK_LINE_END   = 2'b10,
    PK_LONG_HDR   = 2'b11
  } pkt_kind_t;

  typedef struct packed {
    pkt_kind_t   kind;
    logic [1:0]  vc;
    logic [1:0]  width;
    logic        lane_map;
    logic        aligned128;
    logic        frame_first;
    logic        frame_new;
    logic [31:0] word;
  } hsi_word_t;

endpackage : cbnode_pkg

/* File: rtl/cbnode_ram.sv */
// Simple dual-port memory with byte enables and a registered read port
`timescale 1ns/1ps
module cbnode_ram #(
  parameter int W  = 32,
  parameter int AW = 7
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W/8-1:0] wbe_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: contents are undefined until they are written
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < W/8; b++) begin
      if (we_i && wbe_i[b]) begin
        mem[waddr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : cbnode_ram

/* File: sim/cbnode_partner.sv */
// Far-side model: DMA sample source and a slow serial engine sink
`timescale 1ns/1ps
module cbnode_partner (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        dma_ready_i,
  output logic             dma_valid_o,
  output logic [15:0]      dma_data_o,
  output logic             hsi_ready_o
);
  logic [15:0] cnt;
  // Valid drops for one cycle after each take, so the sequencer sees gaps
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_valid_o <= 1'h0;
      cnt         <= 16'h0;
      hsi_ready_o <= 1'h0;
    end else begin
      dma_valid_o <= !(dma_valid_o && dma_ready_i);
      cnt         <= cnt + 16'(dma_valid_o && dma_ready_i);
      hsi_ready_o <= !hsi_ready_o;
    end
  end
  // Idle data shows the inverse, never a stale sample
  assign dma_data_o = dma_valid_o ? cnt + 16'h1 : ~cnt;
endmodule : cbnode_partner

/* File: sim/capture_buffer_node_sequencer_test.sv */
// Register and chain-walk test of the capture buffer node sequencer
`timescale 1ns/1ps
module capture_buffer_node_sequencer_test;
  import cbnode_pkg::*;
  logic MCLK_I = 0, ARST_N_I = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, chirp = 0;
  logic [11:0] aa = 12'h0, ra = 12'h0;
  logic [31:0] wd = 32'h0, rd, rdata, checks = 0, fails = 0, cyc = 0;
  logic [1:0] rsp, bresp, rresp;
  logic aw_r, w_r, bv, ar_r, rv, dv, dr, hv, hr, done;
  logic [15:0] dd;
  logic [6:0] req, rq;
  hsi_word_t hw, lv;
  hsi_word_t q[$];
  int i, k;
  always #2 MCLK_I = ~MCLK_I;
  cbnode_seq dut (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(aw_r),
    .AXI_AWADDR_I(aa), .AXI_WVALID_I(wv), .AXI_WREADY_O(w_r), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF),
    .AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_BRESP_O(bresp), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(ar_r),
    .AXI_ARADDR_I(ra), .AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .CHIRP_AVAIL_I(chirp), .DMA_VALID_I(dv), .DMA_DATA_I(dd), .DMA_READY_O(dr), .DMA_REQ_O(rq),
    .ADC_CRC_I(16'h0), .HSI_VALID_O(hv), .HSI_READY_I(hr), .HSI_O(hw), .CHAIN_DONE_O(done));
  cbnode_partner far (.clk_i(MCLK_I), .arst_n_i(ARST_N_I), .dma_ready_i(dr), .dma_valid_o(dv),
    .dma_data_o(dd), .hsi_ready_o(hr));
  always @(posedge MCLK_I) begin
    if (hv && hr) q.push_back(hw);
    if (chirp) req <= 7'h0;
    else if (rq != 7'h0) req <= rq;
    cyc <= cyc + 32'h1;
    if (cyc == 32'd20000) begin
      fails = fails + 32'h1;
      complete_run();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks = checks + 32'h1;
    if (s !== e) begin
      fails = fails + 32'h1;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task axw(input logic [11:0] a, input logic [31:0] d);
    awv <= 1'h1; wv <= 1'h1; bry <= 1'h1; aa <= a; wd <= d;
    do begin
      @(posedge MCLK_I);
      if (aw_r) awv <= 1'h0;
      if (w_r) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
  endtask : axw
  task axr(input logic [11:0] a);
    arv <= 1'h1; rry <= 1'h1; ra <= a;
    do begin
      @(posedge MCLK_I);
      if (ar_r) arv <= 1'h0;
    end while (!rv);
    rd = rdata; rsp = rresp; rry <= 1'h0;
  endtask : axr
  task complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge MCLK_I);
    ARST_N_I <= 1'h1;
    axw(ADDR_CTRL, 32'h0);
    axw(12'h204, 32'hC0DE1234);
    axw(12'h210, 32'h0);
    for (k = 0; k < 2; k++) begin
      // Second pass continues the packet, checks the buffer CRC and suppresses the DMA request
      axw(12'h200, 32'h2037 | (k << 9) | (k << 10));
      axw(12'h208, (k != 0) ? 32'h70401 : 32'h24004);
      axr(12'h200); chk(rd, 32'h2037 | (k << 9) | (k << 10));
      q.delete();
      chirp <= 1'h1; @(posedge MCLK_I); chirp <= 1'h0;
      do @(posedge MCLK_I); while (!done);
      repeat (8) @(posedge MCLK_I);
      chk(32'(q.size()), 32'd7 - k);
      chk(q[0].kind, PK_LINE_START);
      if (k == 0) chk(32'({q[1].kind, q[1].vc}), 32'({PK_LONG_HDR, 2'h2}));
      if (k == 0) chk(q[1].word, 32'hC0DE1234);
      for (i = 0; i < 4; i++) chk({q[i+2-k].kind, q[i+2-k].width, q[i+2-k].word[15:0]},
        {PK_DATA, WIDTH_14, 16'(i + 1 + 4 * k)});
      chk(q[6-k].kind, PK_LINE_END);
      chk(req, (k != 0) ? 7'h0 : 7'h04);
      // The bench feeds a zero buffer CRC, so only the checked pass may flag an error
      axr(ADDR_STATUS); chk(32'(rd[3]), 32'(k));
    end
    // LVDS pass started by the software trigger: data items only, frame flags ride on each item
    axw(12'h204, 32'hBBBBBBBB);
    axw(12'h200, 32'h20D7);
    q.delete();
    axw(ADDR_CTRL, 32'h5);
    do @(posedge MCLK_I); while (!done);
    repeat (8) @(posedge MCLK_I);
    chk(32'(q.size()), 32'd4);
    lv = q[0];
    chk(32'({lv.kind, lv.width, lv.lane_map}), 32'({PK_DATA, WIDTH_12, 1'h1}));
    chk(32'({lv.aligned128, lv.frame_first, lv.frame_new}), 32'h7);
    chk(q[3].word, 32'd12);
    axr(12'h20C); chk(rsp, RESP_SLVERR);
    complete_run();
  end
endmodule : capture_buffer_node_sequencer_test
